/* File: core/mcst_pkg.sv */
// constants, register map and state encoding of the transceiver control and status timing block
package mcst_pkg;
	// clock and timebase
	localparam int CLK_MHZ  = 200;
	localparam int TICK_US  = 1;
	localparam int TICK_CYC = CLK_MHZ * TICK_US;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

	// documented times, in their own units
	localparam int T_OFF_US          = 100;
	localparam int T_ON_MS           = 2;
	localparam int T_2W_MS           = 300;
	localparam int T_START_MS        = 300;
	localparam int T_COOLED_MIN_S    = 10;
	localparam int T_COOLED_MAX_S    = 90;
	localparam int T_PL2_MS          = 300;
	localparam int T_PD_MS           = 300;
	localparam int T_FAULT_MS        = 1;
	localparam int T_FAULT_COOLED_MS = 50;
	localparam int T_RESET_US        = 10;
	localparam int T_RS_FC_US        = 500;
	localparam int T_RS_MS           = 10;
	localparam int T_LOS_ON_US       = 100;
	localparam int T_LOS_OFF_US      = 100;

	// derived counts in timebase ticks
	localparam int US_PER_MS = 1000;
	localparam int MS_PER_S  = 1000;
	localparam int START_TICKS_DEF  = T_START_MS * US_PER_MS / TICK_US;
	localparam int MGMT_TICKS_DEF   = T_2W_MS * US_PER_MS / TICK_US;
	localparam int COOLED_TICKS_DEF = T_COOLED_MIN_S * MS_PER_S * US_PER_MS / TICK_US;
	localparam int PL2_TICKS_DEF    = T_PL2_MS * US_PER_MS / TICK_US;
	localparam int RS_FC_TICKS_DEF  = T_RS_FC_US / TICK_US;
	localparam int RS_TICKS_DEF     = T_RS_MS * US_PER_MS / TICK_US;
	localparam int LOS_TICKS_DEF    = T_LOS_ON_US / TICK_US;

	// least hold of the transmit-off pin that clears a fault, in clock cycles
	localparam int RESET_HOLD_CYC = (T_RESET_US * CLK_MHZ * 1000 + 999) / 1000;
	localparam logic [11:0] RESET_HOLD_C = 12'(RESET_HOLD_CYC);

	localparam int CNT_W = 27;

	// register map
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_LOSF   = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_FAULTS = 8'h0c;
	localparam int CTRL_COOLED  = 0;
	localparam int CTRL_FC      = 1;
	localparam int CTRL_SOFTOFF = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [6:0] LOSF_RESET = 7'h0a;

	typedef enum logic [3:0] {
		MCST_UNPOWERED = 4'b0001,
		MCST_STARTING  = 4'b0010,
		MCST_RUNNING   = 4'b0100,
		MCST_FAULTED   = 4'b1000
	} mcst_state_e;
endpackage

/* File: core/mcst_top.sv */
// control and status timing logic of a pluggable optical transceiver, with an apb register slave
// Summary of operation
// - transmit-off rising turns the laser off within one clock cycle.
// - transmit-off falling while running turns the laser back on next cycle.
// - management interface reports ready within 300 ms of supply valid.
// - uncooled part reaches running within 300 ms after start or recovery.
// - cooled part reaches running after 10 s and well before 90 s.
// - power level two enable write completes within 300 ms.
// - power level two disable drops to level one next cycle.
// - uncooled part raises fault output one cycle after the fault.
// - cooled part also raises fault output one cycle after the fault.
// - fibre channel rate change settles within 500 us.
// - other rate change settles within 10 ms.
// - signal-lost output rises within 100 us of signal loss.
// - signal-lost output falls within 100 us of signal return.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mcst_top
	import mcst_pkg::*;
#(
	parameter int unsigned START_UP_TICKS   = START_TICKS_DEF,
	parameter int unsigned MGMT_TICKS       = MGMT_TICKS_DEF,
	parameter int unsigned COOLED_MIN_TICKS = COOLED_TICKS_DEF,
	parameter int unsigned PL2_TICKS        = PL2_TICKS_DEF,
	parameter int unsigned RS_FC_TICKS      = RS_FC_TICKS_DEF,
	parameter int unsigned RS_TICKS         = RS_TICKS_DEF,
	parameter int unsigned LOS_TICKS        = LOS_TICKS_DEF
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// module pins and sensors
	input  wire logic        supply_valid_i,
	input  wire logic        tx_off_req_i,
	input  wire logic        rate_select_low_i,
	input  wire logic        rate_select_high_i,
	input  wire logic        laser_fault_det_i,
	input  wire logic        optical_present_i,
	input  wire logic        pl2_on_stop_i,
	input  wire logic        pl2_off_stop_i,
	// status and control outputs
	output logic             laser_enable_o,
	output logic             tx_fault_o,
	output logic             rx_signal_lost_o,
	output logic             mgmt_ready_o,
	output logic             operational_o,
	output logic             high_power_o,
	output logic      [1:0]  rate_applied_o,
	output logic             rate_stable_o
);
	localparam logic [CNT_W-1:0] START_T  = CNT_W'(START_UP_TICKS - 1);
	localparam logic [CNT_W-1:0] COOLED_T = CNT_W'(COOLED_MIN_TICKS + 1);
	localparam logic [CNT_W-1:0] MGMT_T   = CNT_W'(MGMT_TICKS - 1);
	localparam logic [CNT_W-1:0] PL2_T    = CNT_W'(PL2_TICKS - 1);
	localparam logic [CNT_W-1:0] RS_FC_T  = CNT_W'(RS_FC_TICKS - 1);
	localparam logic [CNT_W-1:0] RS_T     = CNT_W'(RS_TICKS - 1);
	localparam logic [6:0]       LOSF_MAX = 7'(LOS_TICKS - 1);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == ADDR_CTRL) || (a == ADDR_LOSF) ||
			(a == ADDR_STATUS) || (a == ADDR_FAULTS);
	endfunction

	logic [7:0]       tick_cnt_reg;
	logic             tick_reg;
	mcst_state_e      state_reg;
	mcst_state_e      state_next;
	logic [CNT_W-1:0] start_cnt_reg;
	logic [CNT_W-1:0] start_cnt_next;
	logic [CNT_W-1:0] mgmt_cnt_reg;
	logic [CNT_W-1:0] pl2_cnt_reg;
	logic             pl2_pend_reg;
	logic [CNT_W-1:0] rs_cnt_reg;
	logic [1:0]       rs_q_reg;
	logic [6:0]       los_cnt_reg;
	logic [11:0]      hold_cnt_reg;
	logic             tx_off_q_reg;
	logic [2:0]       ctrl_reg;
	logic [6:0]       losf_reg;
	logic [15:0]      faults_reg;
	logic             tx_off_fall;
	logic             fault_clear;
	logic [CNT_W-1:0] start_target;
	logic             apb_acc;
	logic             wr_en;
	logic [31:0]      rd_data;

	assign tx_off_fall  = tx_off_q_reg & ~tx_off_req_i;
	assign fault_clear  = tx_off_fall & (hold_cnt_reg >= RESET_HOLD_C);
	assign start_target = ctrl_reg[CTRL_COOLED] ? COOLED_T : START_T;
	assign apb_acc      = psel_i & penable_i & ~pready_o;
	assign wr_en        = psel_i & penable_i & pwrite_i & pready_o & pstrb_i[0];

	// one-microsecond timebase enable
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt_reg <= 8'h00;
			tick_reg     <= 1'b0;
		end else begin
			tick_reg     <= (tick_cnt_reg == TICK_LAST);
			tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 8'h00 : tick_cnt_reg + 8'h01;
		end
	end

	// transmit-off edge and hold length, counted in cycles so 10 us is exact
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_off_q_reg <= 1'b1;
			hold_cnt_reg <= 12'h000;
		end else begin
			tx_off_q_reg <= tx_off_req_i;
			if (!tx_off_req_i) begin
				hold_cnt_reg <= 12'h000;
			end else if (hold_cnt_reg < RESET_HOLD_C) begin
				hold_cnt_reg <= hold_cnt_reg + 12'h001;
			end
		end
	end

	// start-up, running and fault sequencing
	always_comb begin
		state_next     = state_reg;
		start_cnt_next = start_cnt_reg;
		case (state_reg)
			MCST_UNPOWERED: begin
				if (supply_valid_i) begin
					state_next     = MCST_STARTING;
					start_cnt_next = '0;
				end
			end
			MCST_STARTING: begin
				if (laser_fault_det_i) begin
					state_next = MCST_FAULTED;
				end else if (tx_off_fall) begin
					start_cnt_next = '0;
				end else if (tick_reg) begin
					if (start_cnt_reg >= start_target) begin
						state_next = MCST_RUNNING;
					end else begin
						start_cnt_next = start_cnt_reg + CNT_ONE;
					end
				end
			end
			MCST_RUNNING: begin
				if (laser_fault_det_i) begin
					state_next = MCST_FAULTED;
				end
			end
			MCST_FAULTED: begin
				// latched until the host pulses transmit-off long enough or the supply drops
				if (fault_clear) begin
					state_next     = MCST_STARTING;
					start_cnt_next = '0;
				end
			end
			default: begin
				state_next = MCST_UNPOWERED;
			end
		endcase
		if (!supply_valid_i) begin
			state_next = MCST_UNPOWERED;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg     <= MCST_UNPOWERED;
			start_cnt_reg <= '0;
		end else begin
			state_reg     <= state_next;
			start_cnt_reg <= start_cnt_next;
		end
	end

	// laser drive and fault output follow the next state, so each reacts in one cycle
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			laser_enable_o <= 1'b0;
			tx_fault_o     <= 1'b0;
			operational_o  <= 1'b0;
		end else begin
			laser_enable_o <= (state_next == MCST_RUNNING) & ~tx_off_req_i &
				~ctrl_reg[CTRL_SOFTOFF];
			tx_fault_o     <= (state_next == MCST_FAULTED);
			operational_o  <= (state_next == MCST_RUNNING);
		end
	end

	// fault counter for software
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			faults_reg <= 16'h0000;
		end else if ((state_next == MCST_FAULTED) && (state_reg != MCST_FAULTED)) begin
			faults_reg <= faults_reg + 16'h0001;
		end
	end

	// management interface readiness after power is valid
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mgmt_cnt_reg <= '0;
			mgmt_ready_o <= 1'b0;
		end else if (!supply_valid_i) begin
			mgmt_cnt_reg <= '0;
			mgmt_ready_o <= 1'b0;
		end else if (tick_reg && !mgmt_ready_o) begin
			if (mgmt_cnt_reg >= MGMT_T) begin
				mgmt_ready_o <= 1'b1;
			end else begin
				mgmt_cnt_reg <= mgmt_cnt_reg + CNT_ONE;
			end
		end
	end

	// power level two: entry is settled, exit is immediate and wins a tie
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pl2_pend_reg <= 1'b0;
			pl2_cnt_reg  <= '0;
			high_power_o <= 1'b0;
		end else if (pl2_off_stop_i || !supply_valid_i) begin
			pl2_pend_reg <= 1'b0;
			high_power_o <= 1'b0;
		end else if (pl2_on_stop_i && !high_power_o) begin
			pl2_pend_reg <= 1'b1;
			pl2_cnt_reg  <= '0;
		end else if (pl2_pend_reg && tick_reg) begin
			if (pl2_cnt_reg >= PL2_T) begin
				pl2_pend_reg <= 1'b0;
				high_power_o <= 1'b1;
			end else begin
				pl2_cnt_reg <= pl2_cnt_reg + CNT_ONE;
			end
		end
	end

	// rate select: any change restarts settling, limit depends on fibre channel mode
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rs_q_reg       <= 2'b00;
			rs_cnt_reg     <= '0;
			rate_applied_o <= 2'b00;
			rate_stable_o  <= 1'b1;
		end else begin
			rs_q_reg <= {rate_select_high_i, rate_select_low_i};
			if (rs_q_reg != {rate_select_high_i, rate_select_low_i}) begin
				rs_cnt_reg    <= '0;
				rate_stable_o <= 1'b0;
			end else if (!rate_stable_o && tick_reg) begin
				if (rs_cnt_reg >= (ctrl_reg[CTRL_FC] ? RS_FC_T : RS_T)) begin
					rate_applied_o <= rs_q_reg;
					rate_stable_o  <= 1'b1;
				end else begin
					rs_cnt_reg <= rs_cnt_reg + CNT_ONE;
				end
			end
		end
	end

	// loss of signal filter; a mismatch must persist losf+1 ticks before the output flips
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			los_cnt_reg      <= 7'h00;
			rx_signal_lost_o <= 1'b1;
		end else if (optical_present_i != rx_signal_lost_o) begin
			los_cnt_reg <= 7'h00;
		end else if (tick_reg) begin
			if (los_cnt_reg >= losf_reg) begin
				los_cnt_reg      <= 7'h00;
				rx_signal_lost_o <= ~optical_present_i;
			end else begin
				los_cnt_reg <= los_cnt_reg + 7'h01;
			end
		end
	end

	// software registers; filter writes are clamped so the loss deadline holds, the reset value is not clamped
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_reg <= CTRL_RESET;
			losf_reg <= LOSF_RESET;
		end else if (wr_en) begin
			if (paddr_i == ADDR_CTRL) begin
				ctrl_reg <= pwdata_i[2:0];
			end
			if (paddr_i == ADDR_LOSF) begin
				losf_reg <= (pwdata_i[6:0] > LOSF_MAX) ? LOSF_MAX : pwdata_i[6:0];
			end
		end
	end

	// read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr_i)
			ADDR_CTRL:   rd_data = {29'h0, ctrl_reg};
			ADDR_LOSF:   rd_data = {25'h0, losf_reg};
			ADDR_STATUS: rd_data = {20'h0, state_reg, rate_stable_o, rate_applied_o,
				high_power_o, mgmt_ready_o, rx_signal_lost_o, tx_fault_o, laser_enable_o};
			ADDR_FAULTS: rd_data = {16'h0, faults_reg};
			default:     rd_data = 32'h0000_0000;
		endcase
	end

	// one wait state keeps every bus output a flop
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= apb_acc;
			pslverr_o <= apb_acc & ~addr_hit(paddr_i);
			prdata_o  <= (apb_acc && !pwrite_i) ? rd_data : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

/* File: tb/mcst_chk.sv */
// port checker of the transceiver control and status timing block
`timescale 1ns/1ps
`default_nettype none
module mcst_chk (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// pins seen by the module
	input wire logic tx_off_req_i,
	input wire logic laser_fault_det_i,
	input wire logic optical_present_i,
	input wire logic supply_valid_i,
	input wire logic pl2_off_stop_i,
	// outputs of the module
	input wire logic laser_enable_o,
	input wire logic tx_fault_o,
	input wire logic rx_signal_lost_o,
	input wire logic operational_o,
	input wire logic high_power_o
);
	logic [11:0] hi_cnt;
	// length of the present transmit-off high run, saturating so it never wraps
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hi_cnt <= 12'h000;
		end else if (!tx_off_req_i) begin
			hi_cnt <= 12'h000;
		end else if (hi_cnt != 12'hfff) begin
			hi_cnt <= hi_cnt + 12'h001;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_off;
		$rose(tx_off_req_i) |=> !laser_enable_o;
	endproperty
	a_off: assert property (p_off) else $error("laser still on after off request");
	property p_lvl;
		tx_off_req_i [*2] |-> !laser_enable_o;
	endproperty
	a_lvl: assert property (p_lvl) else $error("laser on while off held");
	property p_on;
		$fell(tx_off_req_i) && operational_o && !tx_fault_o && !laser_fault_det_i
			|-> ##[1:2] laser_enable_o;
	endproperty
	a_on: assert property (p_on) else $error("laser not back on");
	property p_flt;
		laser_fault_det_i && operational_o |=> tx_fault_o && !laser_enable_o;
	endproperty
	a_flt: assert property (p_flt) else $error("fault output late");
	property p_latch;
		tx_fault_o && supply_valid_i && tx_off_req_i |=> tx_fault_o;
	endproperty
	a_latch: assert property (p_latch) else $error("fault dropped while off held");
	// a short pulse leaves the fault standing for a margin below the clearing hold
	property p_short;
		$fell(tx_off_req_i) && hi_cnt < 12'h76c && tx_fault_o && supply_valid_i
			|=> tx_fault_o [*3];
	endproperty
	a_short: assert property (p_short) else $error("short pulse cleared fault");
	property p_pl2off;
		pl2_off_stop_i |=> !high_power_o;
	endproperty
	a_pl2off: assert property (p_pl2off) else $error("high power kept");
	property p_los;
		$changed(rx_signal_lost_o) |-> $past(rx_signal_lost_o) == $past(optical_present_i);
	endproperty
	a_los: assert property (p_los) else $error("signal lost flipped wrongly");
endmodule
bind mcst_top mcst_chk u_chk (.core_clk_i, .nrst_i, .tx_off_req_i, .laser_fault_det_i,
	.optical_present_i, .supply_valid_i, .pl2_off_stop_i, .laser_enable_o, .tx_fault_o,
	.rx_signal_lost_o, .operational_o, .high_power_o);
`default_nettype wire

/* File: tb/mcst_host_mdl.sv */
// behavioural host controller driving the transmit-off request
`timescale 1ns/1ps
`default_nettype none
module mcst_host_mdl (
	// clock and command from the bench
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic [11:0] hold_i,
	// request to the module
	output logic             tx_off_o
);
	logic [11:0] left_reg = 12'h000;
	// hold high for the commanded cycles; a hold of 2000 or more clears a fault
	always_ff @(posedge clk_i) begin
		if (go_i) begin
			left_reg <= hold_i;
		end else if (left_reg != 12'h000) begin
			left_reg <= left_reg - 12'h001;
		end
	end
	assign tx_off_o = (left_reg != 12'h000);
endmodule
`default_nettype wire

/* File: tb/mcst_top_tb.sv */
// self-checking bench of the transceiver control and status timing block
`timescale 1ns/1ps
`default_nettype none
module mcst_top_tb;
	import mcst_pkg::*;
	localparam int TK = TICK_CYC;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, txoff, go = 1'b0;
	logic sup = 1'b1, rsl = 1'b0, rsh = 1'b0, fdet = 1'b0, opt = 1'b1, pon = 1'b0, poff = 1'b0;
	logic [11:0] hold = 12'h000;
	logic [3:0] strb = 4'hf;
	logic [1:0] rate;
	logic [6:0] obs;
	int err_count = 0, cmp_count = 0, cyc = 0, n;
	// shortened deadlines keep the run short; one tick is still one microsecond
	localparam int SU_TK = 20, CO_TK = 30, PL_TK = 10, FC_TK = 5, RS_TK = 8, LO_TK = 10;
	mcst_top #(.START_UP_TICKS(SU_TK), .MGMT_TICKS(SU_TK), .COOLED_MIN_TICKS(CO_TK),
		.PL2_TICKS(PL_TK), .RS_FC_TICKS(FC_TK), .RS_TICKS(RS_TK), .LOS_TICKS(LO_TK)) dut (
		.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(strb),
		.prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .supply_valid_i(sup), .tx_off_req_i(txoff),
		.rate_select_low_i(rsl), .rate_select_high_i(rsh), .laser_fault_det_i(fdet),
		.optical_present_i(opt), .pl2_on_stop_i(pon), .pl2_off_stop_i(poff),
		.laser_enable_o(obs[0]), .tx_fault_o(obs[1]), .rx_signal_lost_o(obs[2]),
		.mgmt_ready_o(obs[3]), .operational_o(obs[4]), .high_power_o(obs[5]),
		.rate_applied_o(rate), .rate_stable_o(obs[6]));
	mcst_host_mdl host (.clk_i(clk), .go_i(go), .hold_i(hold), .tx_off_o(txoff));
	// 200 MHz clock and a hang guard well above the expected run
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count = err_count + 1;
			tally_and_finish;
		end
	end
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chkw(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chkb(input string s, input logic e, input int i);
		chkw(s, {31'h0, e}, {31'h0, obs[i]});
	endtask
	// waits until an output reaches a level, with a cap so a stuck output is reported
	task automatic wb(input int i, input logic v, input int lim, output int k);
		k = 0;
		while (obs[i] !== v && k < lim) begin
			@(posedge clk);
			k++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input logic [11:0] h);
		go <= 1'b1;
		hold <= h;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic t_start;
		wb(4, 1'b1, (SU_TK + 2) * TK, n);
		chkb("oper", 1'b1, 4);
		chkb("laser", 1'b1, 0);
		wb(3, 1'b1, 2 * TK, n);
		chkb("mgmt", 1'b1, 3);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chkw("state", 32'h4, {28'h0, rd[11:8]});
	endtask
	task automatic t_regs;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chkw("ctrl", 32'h0, rd);
		apb(1'b0, ADDR_LOSF, 32'h0);
		chkw("losf", 32'h0a, rd);
		apb(1'b1, ADDR_LOSF, 32'hff);
		apb(1'b0, ADDR_LOSF, 32'h0);
		chkw("clamp", 32'(LO_TK - 1), rd);
		apb(1'b1, 8'h10, 32'h1);
		chkw("slverr", 32'h1, {31'h0, er});
		// a write without lane 0 must leave control untouched
		strb <= 4'he;
		apb(1'b1, ADDR_CTRL, 32'h4);
		strb <= 4'hf;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chkw("strb", 32'h0, rd);
		chkw("okerr", 32'h0, {31'h0, er});
		apb(1'b1, ADDR_CTRL, 32'h4);
		repeat (2) @(posedge clk);
		chkb("soft_off", 1'b0, 0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chkb("soft_on", 1'b1, 0);
	endtask
	task automatic t_txoff;
		pulse(12'd50);
		repeat (3) @(posedge clk);
		chkb("laser_off", 1'b0, 0);
		wb(0, 1'b1, 60, n);
		chkb("laser_on", 1'b1, 0);
	endtask
	// supply drop, then a transmit-off release in start-up must restart the count
	task automatic t_supply;
		sup <= 1'b0;
		repeat (2) @(posedge clk);
		chkb("oper_drop", 1'b0, 4);
		chkb("mgmt_drop", 1'b0, 3);
		sup <= 1'b1;
		repeat (10 * TK) @(posedge clk);
		pulse(12'h032);
		wb(4, 1'b1, 30 * TK, n);
		chkw("restart", 32'h1, 32'(n >= (SU_TK - 1) * TK && n <= (SU_TK + 1) * TK));
		chkb("mgmt_back", 1'b1, 3);
	endtask
	task automatic t_pl2;
		pon <= 1'b1;
		@(posedge clk);
		pon <= 1'b0;
		wb(5, 1'b1, (PL_TK + 1) * TK, n);
		chkb("hp_on", 1'b1, 5);
		poff <= 1'b1;
		@(posedge clk);
		poff <= 1'b0;
		@(posedge clk);
		chkb("hp_off", 1'b0, 5);
	endtask
	task automatic t_fault(input logic c);
		apb(1'b1, ADDR_CTRL, {31'h0, c});
		fdet <= 1'b1;
		repeat (2) @(posedge clk);
		chkb("fault", 1'b1, 1);
		chkb("laser_f", 1'b0, 0);
		fdet <= 1'b0;
		pulse(12'd100);
		repeat (110) @(posedge clk);
		chkb("latched", 1'b1, 1);
		pulse(12'd2100);
		wb(1, 1'b0, 2200, n);
		chkb("cleared", 1'b0, 1);
		wb(4, 1'b1, 40 * TK, n);
		chkw("t_run", 32'h1, 32'(c ? (n >= CO_TK * TK && n <= (CO_TK + 3) * TK) :
			n <= (SU_TK + 1) * TK));
		apb(1'b0, ADDR_FAULTS, 32'h0);
		chkw("faults", 32'(c) + 32'h1, rd);
	endtask
	task automatic t_rate(input logic f, input logic l, input logic h, input int tk);
		apb(1'b1, ADDR_CTRL, {30'h0, f, 1'b0});
		rsl <= l;
		rsh <= h;
		repeat (2) @(posedge clk);
		chkb("settling", 1'b0, 6);
		wb(6, 1'b1, (tk + 2) * TK, n);
		chkw("rs_time", 32'h1, 32'(n <= (tk + 1) * TK));
		chkw("rate", {30'h0, h, l}, {30'h0, rate});
	endtask
	task automatic t_los;
		for (int v = 0; v < 2; v++) begin
			opt <= v[0];
			wb(2, !v[0], (LO_TK + 2) * TK, n);
			chkw("los_t", 32'h1, 32'(n >= (LO_TK - 1) * TK && n <= (LO_TK + 1) * TK));
			chkb("los", !v[0], 2);
		end
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_start;
		t_regs;
		t_txoff;
		t_supply;
		t_pl2;
		t_fault(1'b0);
		t_fault(1'b1);
		t_rate(1'b0, 1'b1, 1'b0, RS_TK);
		t_rate(1'b1, 1'b1, 1'b1, FC_TK);
		t_los;
		tally_and_finish;
	end
endmodule
`default_nettype wire
